//--- rtl/rs_pkg.sv
package rs_pkg;
    // Array geometry and data path.
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int ADDR_W = 48;
    localparam int DATA_W = 256;
    localparam int CNT_W = 16;
    localparam int ERR_W = 8;
    localparam int TEST_W = 32;
    localparam int IDA_W = 7;
    localparam int IDD_W = 32;
    localparam int SECT_WORDS = 16;
    localparam int BEAT_W = 4;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 4'hF;
    // Command encodings shared with the channels.
    localparam logic [1:0] CMD_IDENT = 2'h0;
    localparam logic [1:0] CMD_ERASE = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    // Lowest counter bits of the fill checks.
    localparam int RX_SPACE_LSB = 5;
    localparam int TX_AVAIL_LSB = 4;
    // Register map on the APB side.
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] REG_TIMEOUT = 12'h000;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] REG_SECTOR = 12'h008;
    localparam int STS_BUSY = 0;
    localparam int STS_ERR = 1;
    localparam int STS_LINK_LSB = 8;
    // Gray-coded sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ISSUE = 3'h1,
        ST_ACK = 3'h3,
        ST_CHECK = 3'h2,
        ST_MOVE = 3'h6,
        ST_GAP = 3'h7,
        ST_DRAIN = 3'h5
    } rs_state_e;

    // Channel number to one-hot vector.
    function automatic logic [NUM_CH-1:0] rs_onehot(input logic [CH_W-1:0] s);
        rs_onehot = '0;
        rs_onehot[s] = 1'b1;
    endfunction
endpackage

//--- rtl/rs_core_if.sv
`timescale 1ns/1ps
interface rs_core_if;
    import rs_pkg::*;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] len;
    logic [ADDR_W-1:0] ch_addr [NUM_CH];
    logic [ADDR_W-1:0] ch_len [NUM_CH];
    logic go;
    logic is_wr;
    logic [CH_W-1:0] sel;
    logic tx_rd;
    logic [NUM_CH-1:0] rx_rd;
    logic done;
    modport plan (input start, input len, output ch_addr, output ch_len);
    modport beat (input go, input is_wr, input sel, output tx_rd, output rx_rd, output done);
    modport ctrl (output start, output len, output go, output is_wr, output sel,
                  input ch_addr, input ch_len, input tx_rd, input rx_rd, input done);
endinterface

//--- rtl/rs_stripe_plan.sv
`timescale 1ns/1ps
module rs_stripe_plan (
    // Plan port.
    rs_core_if.plan pif
);
    import rs_pkg::*;

    // Each channel takes every eighth sector from its first-row offset.
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
            logic [CH_W-1:0] ofs;
            logic below;
            logic [ADDR_W-1:0] tail;
            assign ofs = CH_W'(c) - pif.start[CH_W-1:0];
            assign below = CH_W'(c) < pif.start[CH_W-1:0];
            assign pif.ch_addr[c] = (pif.start >> CH_W) + {{(ADDR_W-1){1'b0}}, below}; // see R25
            assign tail = pif.len - ADDR_W'(ofs) - ADDR_W'(1);
            assign pif.ch_len[c] = (pif.len > ADDR_W'(ofs)) ? (tail >> CH_W) + ADDR_W'(1) : '0; // see R25
        end
    endgenerate
endmodule

//--- rtl/rs_beat_seq.sv
`timescale 1ns/1ps
module rs_beat_seq (
    // Clock and reset.
    input logic clk,
    input logic reset_n,
    // Burst port.
    rs_core_if.beat bif
);
    import rs_pkg::*;

    logic act_q;
    logic wr_q;
    logic [CH_W-1:0] sel_q;
    logic [BEAT_W-1:0] cnt_q;
    logic tx_rd_q;
    logic [NUM_CH-1:0] rx_rd_q;
    logic done_q;
    logic act_d;
    logic wr_d;
    logic [CH_W-1:0] sel_d;

    // A burst runs gaplessly to the sector's last word.
    assign act_d = bif.go | (act_q & (cnt_q != BEAT_LAST));
    assign wr_d = bif.go ? bif.is_wr : wr_q;
    assign sel_d = bif.go ? bif.sel : sel_q;

    // Registered strobes give the fifo sides clean edges.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            sel_q <= '0;
            cnt_q <= '0;
            tx_rd_q <= 1'b0;
            rx_rd_q <= '0;
            done_q <= 1'b0;
        end else begin
            act_q <= act_d;
            wr_q <= wr_d;
            sel_q <= sel_d;
            cnt_q <= bif.go ? '0 : (act_q ? cnt_q + BEAT_W'(1) : cnt_q);
            tx_rd_q <= act_d & wr_d; // see R19
            rx_rd_q <= (act_d & ~wr_d) ? rs_onehot(sel_d) : '0; // see R22
            done_q <= act_q & (cnt_q == BEAT_LAST);
        end
    end

    assign bif.tx_rd = tx_rd_q;
    assign bif.rx_rd = rx_rd_q;
    assign bif.done = done_q;

    beat_done_a: assert property (@(posedge clk) disable iff (!reset_n) bif.go |-> ##17 done_q) // see R19
        else $error("Burst did not end after sixteen words.");
    beat_gapless_a: assert property (@(posedge clk) disable iff (!reset_n) // see R22
        $rose(act_q) |-> ##15 (act_q && cnt_q == BEAT_LAST && $past(act_q, 14)))
        else $error("Sector burst had a gap or wrong length.");
endmodule

//--- rtl/rs_stripe_ctrl.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// R1: Active-low reset and clock shared with channels.
// R2: Command 00 identify, 01 erase, 10 write, 11 read.
// R3: Requester gives 48-bit start sector address.
// R4: Requester gives length within remaining capacity.
// R5: Requester asks only while busy is low.
// R6: Busy held during command; requests refused meanwhile.
// R7: Capacity is eight times channel zero; reset zero.
// R8: Error flag sticky until reset on any error.
// R9: Error vector holds one byte per channel.
// R10: Receive count unused upper bits driven ones.
// R11: Receive write only with upper count not ones.
// R12: Transmit count unused upper bits driven zeros.
// R13: Transmit read only with upper count nonzero.
// R14: Transmit data arrives one cycle after read.
// R15: Channel test, identify and link signals passed through.
// R16: One shared timeout value in clock cycles.
// R17: Each write sector goes to one channel.
// R18: Write needs one user sector, two free.
// R19: Read strobe high sixteen cycles per sector.
// R20: Each read sector comes from one channel.
// R21: Read needs one channel sector, two free.
// R22: Write strobe high sixteen cycles per sector.
// R23: Low three sector bits pick channel; then increment.
// R24: Per-channel address and length sent to channels.
// R25: Channel address and length follow the striping.
// R26: Busy drops after channels and data finish.
module rs_stripe_ctrl #(
    parameter int CHAN_FIFO_WORDS = 512,
    parameter int GAP_CYCLES = 4,
    parameter logic [31:0] TIMEOUT_RST = 32'h0100_0000
) (
    // Clock and reset.
    input logic clk,
    input logic reset_n,
    // APB register port.
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [rs_pkg::APB_AW-1:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command port.
    input logic [1:0] cmd_code,
    input logic [rs_pkg::ADDR_W-1:0] start_sector,
    input logic [rs_pkg::ADDR_W-1:0] sector_count,
    input logic cmd_request,
    output logic cmd_busy,
    output logic [rs_pkg::ADDR_W-1:0] total_capacity,
    output logic error_flag,
    output logic [rs_pkg::NUM_CH*rs_pkg::ERR_W-1:0] error_type_vector,
    // User receive fifo.
    input logic [rs_pkg::CNT_W-1:0] rx_user_fifo_count,
    output logic rx_user_fifo_wr,
    output logic [rs_pkg::DATA_W-1:0] rx_user_fifo_wdata,
    // User transmit fifo.
    input logic [rs_pkg::CNT_W-1:0] tx_user_fifo_count,
    input logic tx_user_fifo_empty,
    output logic tx_user_fifo_rd,
    input logic [rs_pkg::DATA_W-1:0] tx_user_fifo_rdata,
    // Channel command side.
    output logic [1:0] chan_cmd_code,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::ADDR_W-1:0] chan_start_sector,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::ADDR_W-1:0] chan_sector_count,
    output logic [rs_pkg::NUM_CH-1:0] chan_cmd_request,
    input logic [rs_pkg::NUM_CH-1:0] chan_busy,
    input logic [rs_pkg::ADDR_W-1:0] chan0_capacity,
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::ERR_W-1:0] chan_error_type,
    output logic [31:0] channel_timeout,
    // Channel data fifos.
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::CNT_W-1:0] chan_tx_fifo_count,
    output logic [rs_pkg::NUM_CH-1:0] chan_tx_fifo_wr,
    output logic [rs_pkg::DATA_W-1:0] chan_tx_fifo_wdata,
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::CNT_W-1:0] chan_rx_fifo_count,
    output logic [rs_pkg::NUM_CH-1:0] chan_rx_fifo_rd,
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::DATA_W-1:0] chan_rx_fifo_rdata,
    // Channel monitor pass-through.
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::TEST_W-1:0] chan_test_in,
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::IDA_W-1:0] chan_ident_addr_in,
    input logic [rs_pkg::NUM_CH-1:0] chan_ident_strobe_in,
    input logic [rs_pkg::NUM_CH-1:0][rs_pkg::IDD_W-1:0] chan_ident_data_in,
    input logic [rs_pkg::NUM_CH-1:0] chan_link_up_in,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::TEST_W-1:0] channel_test_bus,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::IDA_W-1:0] ident_wr_addr,
    output logic [rs_pkg::NUM_CH-1:0] ident_wr_strobe,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::IDD_W-1:0] ident_wr_data,
    output logic [rs_pkg::NUM_CH-1:0] channel_link_up
);
    import rs_pkg::*;

    localparam logic [CNT_W-1:0] TX_FREE_MAX = CNT_W'(CHAN_FIFO_WORDS - 2 * SECT_WORDS);
    localparam logic [7:0] GAP_LAST = 8'(GAP_CYCLES - 1);

    rs_state_e state_q;
    logic busy_q;
    logic [1:0] cmd_q;
    logic [ADDR_W-1:0] cur_q;
    logic [ADDR_W-1:0] rem_q;
    logic [NUM_CH-1:0] mask_q;
    logic [NUM_CH-1:0] ack_q;
    logic [7:0] gap_q;
    logic [ADDR_W-1:0] cap_q;
    logic err_q;
    logic [NUM_CH*ERR_W-1:0] etype_q;
    logic [1:0] ccmd_q;
    logic [NUM_CH-1:0][ADDR_W-1:0] caddr_q;
    logic [NUM_CH-1:0][ADDR_W-1:0] clen_q;
    logic [NUM_CH-1:0] creq_q;
    logic tx_d1_q;
    logic [NUM_CH-1:0] rx_d1_q;
    logic [CH_W-1:0] sel_d1_q;
    logic [NUM_CH-1:0] ctx_wr_q;
    logic [DATA_W-1:0] ctx_wdata_q;
    logic urx_wr_q;
    logic [DATA_W-1:0] urx_wdata_q;
    logic [31:0] timeout_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [NUM_CH-1:0][TEST_W-1:0] test_q;
    logic [NUM_CH-1:0][IDA_W-1:0] ida_q;
    logic [NUM_CH-1:0] ids_q;
    logic [NUM_CH-1:0][IDD_W-1:0] idd_q;
    logic [NUM_CH-1:0] link_q;
    logic [CH_W-1:0] sel;
    logic is_wr;
    logic is_data;
    logic tx_avail;
    logic rx_space;
    logic chan_tx_free;
    logic chan_rx_avail;
    logic move_ok;
    logic pipe_busy;
    logic [NUM_CH-1:0] data_mask;

    rs_core_if core_if ();

    rs_stripe_plan u_plan (
        .pif(core_if.plan)
    );

    rs_beat_seq u_beat (
        .clk(clk),
        .reset_n(reset_n),
        .bif(core_if.beat)
    );

    // Flow checks on the active channel and user fifos.
    assign sel = cur_q[CH_W-1:0]; // see R23
    assign is_wr = (cmd_q == CMD_WRITE);
    assign is_data = (cmd_q == CMD_WRITE) || (cmd_q == CMD_READ); // see R2
    assign tx_avail = |tx_user_fifo_count[CNT_W-1:TX_AVAIL_LSB]; // see R13
    assign rx_space = ~&rx_user_fifo_count[CNT_W-1:RX_SPACE_LSB]; // see R11
    assign chan_tx_free = chan_tx_fifo_count[sel] <= TX_FREE_MAX;
    assign chan_rx_avail = |chan_rx_fifo_count[sel][CNT_W-1:TX_AVAIL_LSB];
    assign move_ok = is_wr ? (tx_avail & chan_tx_free) : (chan_rx_avail & rx_space); // see R18 R21
    assign pipe_busy = tx_d1_q | (|rx_d1_q) | core_if.tx_rd | (|core_if.rx_rd);

    // The planner sees the latched start and length.
    assign core_if.start = cur_q;
    assign core_if.len = rem_q;
    assign core_if.is_wr = is_wr;
    assign core_if.sel = sel;
    assign core_if.go = (state_q == ST_CHECK) && (rem_q != '0) && move_ok;

    // Only channels owning a sector join a data command.
    always_comb begin
        data_mask = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            data_mask[c] = (core_if.ch_len[c] != '0);
        end
    end

    // Command sequencer; a request while busy is not taken.
    always_ff @(posedge clk or negedge reset_n) begin // see R1
        if (!reset_n) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            cmd_q <= CMD_IDENT;
            cur_q <= '0;
            rem_q <= '0;
            mask_q <= '0;
            ack_q <= '0;
            gap_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_request && !busy_q) begin // see R6
                        busy_q <= 1'b1;
                        cmd_q <= cmd_code;
                        cur_q <= start_sector;
                        rem_q <= sector_count;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    mask_q <= is_data ? data_mask : {NUM_CH{1'b1}}; // see R24
                    ack_q <= '0;
                    state_q <= ST_ACK;
                end
                ST_ACK: begin
                    // Each commanded channel must show busy first, or drain could miss it.
                    ack_q <= ack_q | (chan_busy & mask_q);
                    if (((ack_q | chan_busy) & mask_q) == mask_q) begin
                        state_q <= is_data ? ST_CHECK : ST_DRAIN;
                    end
                end
                ST_CHECK: begin
                    if (rem_q == '0) begin
                        state_q <= ST_DRAIN;
                    end else if (move_ok) begin
                        state_q <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (core_if.done) begin
                        cur_q <= cur_q + ADDR_W'(1); // see R23
                        rem_q <= rem_q - ADDR_W'(1);
                        gap_q <= '0;
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // Fifo counters lag the strobes, so they are rechecked only after a settle time.
                    gap_q <= gap_q + 8'h01;
                    if (gap_q >= GAP_LAST) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_DRAIN: begin
                    if (((chan_busy & mask_q) == '0) && !pipe_busy) begin // see R26
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    busy_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // One request pulse with striped address and length.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ccmd_q <= CMD_IDENT;
            caddr_q <= '0;
            clen_q <= '0;
            creq_q <= '0;
        end else begin
            creq_q <= '0;
            if (state_q == ST_ISSUE) begin
                ccmd_q <= cmd_q; // see R2
                creq_q <= is_data ? data_mask : {NUM_CH{1'b1}}; // see R24
                for (int c = 0; c < NUM_CH; c++) begin
                    caddr_q[c] <= core_if.ch_addr[c]; // see R25
                    clen_q[c] <= core_if.ch_len[c];
                end
            end
        end
    end

    // Fifo read data trails its strobe, so routing lags a cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_d1_q <= 1'b0;
            rx_d1_q <= '0;
            sel_d1_q <= '0;
            ctx_wr_q <= '0;
            ctx_wdata_q <= '0;
            urx_wr_q <= 1'b0;
            urx_wdata_q <= '0;
        end else begin
            tx_d1_q <= core_if.tx_rd;
            rx_d1_q <= core_if.rx_rd;
            sel_d1_q <= sel;
            ctx_wr_q <= tx_d1_q ? rs_onehot(sel_d1_q) : '0; // see R14 R17
            ctx_wdata_q <= tx_user_fifo_rdata;
            urx_wr_q <= |rx_d1_q; // see R20
            urx_wdata_q <= chan_rx_fifo_rdata[sel_d1_q];
        end
    end

    // Status; the error flag clears only with reset.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_q <= '0;
            err_q <= 1'b0;
            etype_q <= '0;
        end else begin
            cap_q <= chan0_capacity << CH_W; // see R7
            err_q <= err_q | (|chan_error_type); // see R8
            etype_q <= chan_error_type; // see R9
        end
    end

    // Channel monitor signals, registered once.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_q <= '0;
            ida_q <= '0;
            ids_q <= '0;
            idd_q <= '0;
            link_q <= '0;
        end else begin
            test_q <= chan_test_in; // see R15
            ida_q <= chan_ident_addr_in;
            ids_q <= chan_ident_strobe_in;
            idd_q <= chan_ident_data_in;
            link_q <= chan_link_up_in;
        end
    end

    // Zero-wait APB slave; the answer is built in the setup cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_q <= 1'b0;
                prdata_q <= '0;
                case (paddr)
                    REG_TIMEOUT: prdata_q <= timeout_q;
                    REG_STATUS: begin
                        prdata_q[STS_BUSY] <= busy_q;
                        prdata_q[STS_ERR] <= err_q;
                        prdata_q[STS_LINK_LSB +: NUM_CH] <= link_q;
                    end
                    REG_SECTOR: prdata_q <= cur_q[31:0];
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // Shared timeout, written at the access edge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_q <= TIMEOUT_RST;
        end else if (psel && penable && pready_q && pwrite && paddr == REG_TIMEOUT) begin
            timeout_q <= pwdata; // see R16
        end
    end

    // Registered outputs.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cmd_busy = busy_q;
    assign total_capacity = cap_q;
    assign error_flag = err_q;
    assign error_type_vector = etype_q;
    assign rx_user_fifo_wr = urx_wr_q;
    assign rx_user_fifo_wdata = urx_wdata_q;
    assign tx_user_fifo_rd = core_if.tx_rd;
    assign chan_cmd_code = ccmd_q;
    assign chan_start_sector = caddr_q;
    assign chan_sector_count = clen_q;
    assign chan_cmd_request = creq_q;
    assign channel_timeout = timeout_q;
    assign chan_tx_fifo_wr = ctx_wr_q;
    assign chan_tx_fifo_wdata = ctx_wdata_q;
    assign chan_rx_fifo_rd = core_if.rx_rd;
    assign channel_test_bus = test_q;
    assign ident_wr_addr = ida_q;
    assign ident_wr_strobe = ids_q;
    assign ident_wr_data = idd_q;
    assign channel_link_up = link_q;

    busy_take_a: assert property (@(posedge clk) disable iff (!reset_n) // see R6
        (cmd_request && !cmd_busy) |=> cmd_busy)
        else $error("Accepted request did not raise busy.");
    busy_refuse_a: assert property (@(posedge clk) disable iff (!reset_n) // see R6
        (cmd_busy && state_q != ST_IDLE) |=> $stable(cmd_q))
        else $error("Command changed while busy.");
    tx_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // see R13
        $rose(tx_user_fifo_rd) |-> $past(tx_avail && chan_tx_free))
        else $error("Transmit read without data or space.");
    rx_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // see R11
        $rose(rx_user_fifo_wr) |-> $past(rx_space, 3))
        else $error("Receive write without two free sectors.");
    cap_scale_a: assert property (@(posedge clk) disable iff (!reset_n) // see R7
        ##1 total_capacity == ($past(chan0_capacity) << CH_W))
        else $error("Capacity is not eight times channel zero.");
    err_sticky_a: assert property (@(posedge clk) disable iff (!reset_n) // see R8
        ((|chan_error_type) || error_flag) |=> error_flag)
        else $error("Error flag missed or cleared.");
    err_map_a: assert property (@(posedge clk) disable iff (!reset_n) // see R9
        ##1 error_type_vector[NUM_CH*ERR_W-1 -: ERR_W] == $past(chan_error_type[NUM_CH-1]))
        else $error("Top error byte is not channel seven.");
    tx_route_a: assert property (@(posedge clk) disable iff (!reset_n) // see R17
        (|chan_tx_fifo_wr) |-> $onehot(chan_tx_fifo_wr))
        else $error("Write data routed to several channels.");
    drain_a: assert property (@(posedge clk) disable iff (!reset_n) // see R26
        $fell(cmd_busy) |-> ($past(chan_busy & mask_q) == '0))
        else $error("Busy dropped while a channel was working.");
endmodule

//--- testbench/rs_chan_model.sv
`timescale 1ns/1ps
module rs_chan_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Channel side.
    input wire logic [rs_pkg::NUM_CH-1:0] chan_cmd_request,
    output logic [rs_pkg::NUM_CH-1:0] chan_busy,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::CNT_W-1:0] chan_tx_fifo_count,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::CNT_W-1:0] chan_rx_fifo_count,
    output logic [rs_pkg::NUM_CH-1:0][rs_pkg::DATA_W-1:0] chan_rx_fifo_rdata
);
    import rs_pkg::*;
    logic [7:0] hold_q [NUM_CH];
    // A commanded channel stays busy past the data phase.
    always_ff @(posedge clk or negedge reset_n) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!reset_n) hold_q[c] <= 8'h00;
            else if (chan_cmd_request[c]) hold_q[c] <= 8'hC8;
            else if (hold_q[c] != 8'h00) hold_q[c] <= hold_q[c] - 8'h01;
        end
    end
    // Empty transmit fifos; one marked sector per receive fifo.
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            chan_busy[c] = hold_q[c] != 8'h00;
            chan_tx_fifo_count[c] = 16'h0000;
            chan_rx_fifo_count[c] = 16'h0010;
            chan_rx_fifo_rdata[c] = {32{8'(c)}};
        end
    end
endmodule

//--- testbench/test_rs_stripe_ctrl.sv
`timescale 1ns/1ps
module test_rs_stripe_ctrl;
    import rs_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, cmd_request, cmd_busy, error_flag, e;
    logic rx_user_fifo_wr, tx_user_fifo_rd, tx_user_fifo_empty;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, channel_timeout, r;
    logic [1:0] cmd_code, chan_cmd_code;
    logic [ADDR_W-1:0] start_sector, sector_count, total_capacity, chan0_capacity;
    logic [63:0] error_type_vector;
    logic [CNT_W-1:0] rx_user_fifo_count, tx_user_fifo_count;
    logic [DATA_W-1:0] rx_user_fifo_wdata, tx_user_fifo_rdata, chan_tx_fifo_wdata, first_q;
    logic [NUM_CH-1:0][ADDR_W-1:0] chan_start_sector, chan_sector_count;
    logic [NUM_CH-1:0] chan_cmd_request, chan_busy, chan_tx_fifo_wr, chan_rx_fifo_rd;
    logic [NUM_CH-1:0] chan_ident_strobe_in, ident_wr_strobe, chan_link_up_in, channel_link_up;
    logic [NUM_CH-1:0][ERR_W-1:0] chan_error_type;
    logic [NUM_CH-1:0][CNT_W-1:0] chan_tx_fifo_count, chan_rx_fifo_count;
    logic [NUM_CH-1:0][DATA_W-1:0] chan_rx_fifo_rdata;
    logic [NUM_CH-1:0][TEST_W-1:0] chan_test_in, channel_test_bus;
    logic [NUM_CH-1:0][IDA_W-1:0] chan_ident_addr_in, ident_wr_addr;
    logic [NUM_CH-1:0][IDD_W-1:0] chan_ident_data_in, ident_wr_data;
    int n_mismatch, n_checks, n_req, n_trd, n_rwr, n_wr[NUM_CH], n_rd[NUM_CH];
    rs_stripe_ctrl rs_stripe_ctrl_i (.*);
    rs_chan_model rs_chan_model_i (.*);
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Strobe tallies and the user transmit fifo.
    always @(posedge clk) begin
        n_req += (|chan_cmd_request);
        n_trd += tx_user_fifo_rd;
        if (rx_user_fifo_wr && n_rwr == 0) first_q = rx_user_fifo_wdata;
        n_rwr += rx_user_fifo_wr;
        for (int c = 0; c < NUM_CH; c++) begin
            n_wr[c] += chan_tx_fifo_wr[c];
            n_rd[c] += chan_rx_fifo_rd[c];
        end
        if (tx_user_fifo_rd) tx_user_fifo_rdata <= {8{32'(n_trd)}};
    end
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready.
    task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        chk(pready, 1'b1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Command, plan checks, a refused poke, then idle.
    task automatic cmd(input logic [1:0] c, input logic [ADDR_W-1:0] a, l, input logic [NUM_CH-1:0] m);
        int t, n;
        @(posedge clk);
        {cmd_code, start_sector, sector_count, cmd_request} <= {c, a, l, 1'b1};
        @(posedge clk);
        cmd_request <= 1'b0;
        for (t = 0; chan_cmd_request === '0 && t < 50; t++) @(posedge clk);
        chk(chan_cmd_request, m);
        chk(chan_cmd_code, c);
        for (int k = 0; k < NUM_CH; k++) if (c[1] && m[k]) begin
            n = 0;
            for (logic [ADDR_W-1:0] s = a; s < a + l; s++) n += (s[2:0] == k);
            chk(chan_start_sector[k], (a >> 3) + (k < a[2:0]));
            chk(chan_sector_count[k], n);
        end
        cmd_request <= 1'b1;
        @(posedge clk);
        cmd_request <= 1'b0;
        for (t = 0; cmd_busy !== 1'b0 && t < 3000; t++) @(posedge clk);
        chk(cmd_busy, 1'b0);
    endtask
    task automatic test_regs();
        chk(total_capacity, 0);
        apb(1'b0, REG_TIMEOUT, 0);
        chk({e, r}, 33'h0_0100_0000);
        apb(1'b1, REG_TIMEOUT, 32'h0000_1234);
        @(posedge clk);
        chk(channel_timeout, 32'h0000_1234);
        apb(1'b0, 12'h0FC, 0);
        chk(e, 1'b1);
        {chan0_capacity, chan_error_type[3], chan_test_in[5]} <= {48'h64, 8'h21, 32'hA5A5_0F0F};
        {chan_link_up_in, chan_ident_strobe_in} <= 16'h8142;
        repeat (3) @(posedge clk);
        chk(total_capacity, 48'h320);
        chk(error_type_vector, 64'h2100_0000);
        chk({channel_link_up, ident_wr_strobe, channel_test_bus[5]}, 48'h8142_A5A5_0F0F);
        chan_error_type[3] <= 8'h00;
        repeat (3) @(posedge clk);
        chk(error_flag, 1'b1);
        $display("regs done");
    endtask
    task automatic test_write();
        fork
            cmd(CMD_WRITE, 48'h5, 48'h3, 8'hE0);
            begin
                repeat (60) @(posedge clk);
                chk(n_trd, 0);
                tx_user_fifo_count <= 16'h0010;
            end
        join
        chk({n_trd, n_wr[5], n_wr[6], n_wr[7], n_wr[0], n_req}, {32'd48, 32'd16, 32'd16, 32'd16, 32'd0, 32'd1});
        $display("write done");
    endtask
    task automatic test_read();
        cmd(CMD_READ, 48'hE, 48'h2, 8'hC0);
        chk({n_rwr, n_rd[6], n_rd[7], n_req}, {32'd32, 32'd16, 32'd16, 32'd2});
        chk(first_q, {32{8'h06}});
        for (int k = 0; k < 2; k++) cmd(2'(k), 0, 1, 8'hFF);
        $display("read done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard.
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
    // Reset, then the tests.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, cmd_code, start_sector, sector_count, cmd_request} = '0;
        {chan0_capacity, chan_error_type, rx_user_fifo_count, tx_user_fifo_empty, tx_user_fifo_rdata} = '0;
        {chan_test_in, chan_ident_addr_in, chan_ident_strobe_in, chan_ident_data_in, chan_link_up_in} = '0;
        {reset_n, tx_user_fifo_count} = {1'b0, 16'h000F};
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        test_regs();
        test_write();
        test_read();
        print_verdict();
    end
endmodule
